// *** design/pfg_map.vh ***
// constants for the program flash mode gating block
// assumes an 8-bit register port and a 13-bit (8 Kbyte) flash address
`ifndef PFG_MAP_VH
`define PFG_MAP_VH

// ==========================================
// register offsets
`define PFG_REG_FLASH_CONTROL_STATUS 8'h00
`define PFG_REG_CTRL 8'h01
`define PFG_REG_STAT 8'h02
`define PFG_REG_REFUSED 8'h03

// ==========================================
// flash_control_status fields and unlock keys
`define PFG_FLASH_CONTROL_STATUS_PGM 0
`define PFG_FLASH_CONTROL_STATUS_LAT 1
`define PFG_FLASH_CONTROL_STATUS_OPT 2
`define PFG_FLASH_CONTROL_STATUS_RST 3'h0
`define PFG_KEY1 8'h56
`define PFG_KEY2 8'hae

// ==========================================
// control and status fields
`define PFG_CTRL_IAP 0
`define PFG_STAT_MODE_LO 0
`define PFG_STAT_MODE_HI 1
`define PFG_STAT_IAP 2
`define PFG_STAT_UNLOCK 3
`define PFG_STAT_WLOCK 4
`define PFG_STAT_VECT 5

// ==========================================
// operating modes
`define PFG_MODE_APP 2'h0
`define PFG_MODE_ICC 2'h1
`define PFG_MODE_TOOL 2'h2

// ==========================================
// regions
`define PFG_RGN_S0 2'h0
`define PFG_RGN_S1 2'h1
`define PFG_RGN_OPT 2'h2
`define PFG_RGN_EE 2'h3

// ==========================================
// sizes and counts
`define PFG_GROUP_MAX 6'h20
`define PFG_ENTRY_EDGES 4'h5
`define PFG_BOUND_SHIFT 9
`define PFG_OPT_LOCK_BIT 7
// idle pin levels {reset pin, link clock, link data, socket}
`define PFG_PIN_IDLE 4'he

`endif

// *** design/pfg_sync.v ***
// two-flop synchroniser for levels arriving from outside the clock domain
// assumes clk_i is the core clock; en_i freezes the stages
module pfg_sync #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}
) (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   input wire en_i,
   // data
   input wire [W-1:0] d_i,
   output reg [W-1:0] q_o
);
   reg [W-1:0] meta_q;

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         // reset to the idle level so no false edge follows reset
         meta_q <= RST;
         q_o <= RST;
      end else if (en_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

// *** design/pfg_buf2.v ***
// two-entry buffer with valid/ready on both sides
// assumes both sides on clk_i; en_i low freezes the entries
module pfg_buf2 #(
   parameter W = 22
) (
   // clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   input wire en_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem_q [0:1];
   reg wp_q;
   reg rp_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready_o = en_i && (cnt_q != 2'h2);
   assign out_valid_o = en_i && (cnt_q != 2'h0);
   assign out_data_o = mem_q[rp_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always @(posedge clk_i) begin
      if (push) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else if (en_i) begin
         if (push) begin
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

// *** design/pfg_top.v ***
// program flash mode gating: mode entry, unlock keys and region filter
// assumes core-side ports are on clk_i; link pins and reset pin are asynchronous
//
// Notes on behaviour
// - byte or group of up to 32 writes
// - erase touches only the addressed sector
// - sector 0 boundary comes from option byte
// - tool modes may write all regions until the write lock is set, then eeprom only
// - application mode: sector 1 and eeprom only
// - application mode never writes sector 0
// - detect entry sequence while reset held low
// - in-circuit entry selects system memory vector
// - in-circuit writes only from the ram driver
// - application driver must run from sector 0
// - write lock option is permanent
`include "pfg_map.vh"

module pfg_top #(
   parameter AW = 13,
   parameter GROUP_MAX = `PFG_GROUP_MAX
) (
   // clock, reset, enable
   input wire clk_i,
   input wire sys_rst_i,
   input wire ce_i,
   // device pins
   input wire rst_pin_n_i,
   input wire link_serial_clock_pin_i,
   input wire link_serial_data_pin_i,
   input wire tool_socket_i,
   // option byte contents from the nonvolatile store
   input wire [7:0] opt_byte_i,
   // core state
   input wire exec_in_sector0_i,
   input wire exec_in_ram_i,
   output reg boot_vector_sys_o,
   // register port
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   // program / erase requests from the core
   input wire cmd_valid_i,
   output wire cmd_ready_o,
   input wire cmd_erase_i,
   input wire cmd_eeprom_i,
   input wire cmd_last_i,
   input wire [AW-1:0] cmd_addr_i,
   input wire [7:0] cmd_data_i,
   // requests passed to the array
   output wire fl_valid_o,
   input wire fl_ready_i,
   output wire fl_erase_o,
   output wire [1:0] fl_region_o,
   output wire [AW-1:0] fl_addr_o,
   output wire [7:0] fl_data_o
);
   localparam BW = 1 + 2 + AW + 8;
   localparam ST_RUN = 2'h0;
   localparam ST_HELD = 2'h1;
   localparam ST_ARMED = 2'h2;

   // ==========================================
   // pin synchronisers
   wire rst_pin_n_s;
   wire link_clk_s;
   wire link_dat_s;
   wire tool_s;

   pfg_sync #(
      .W(4),
      .RST(`PFG_PIN_IDLE)
   ) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(ce_i),
      .d_i({rst_pin_n_i, link_serial_clock_pin_i, link_serial_data_pin_i, tool_socket_i}),
      .q_o({rst_pin_n_s, link_clk_s, link_dat_s, tool_s})
   );

   // ==========================================
   // state
   reg [1:0] entry_st_q;
   reg [3:0] edge_cnt_q;
   reg link_clk_prev_q;
   reg [1:0] mode_q;
   reg [2:0] flash_control_status_q;
   reg key1_seen_q;
   reg unlocked_q;
   reg iap_en_q;
   reg wlock_q;
   reg [7:0] bound_q;
   reg opt_valid_q;
   reg [5:0] grp_cnt_q;
   reg [7:0] refused_q;

   wire link_rise = link_clk_s && !link_clk_prev_q;

   // ==========================================
   // region decode
   function [1:0] region_of;
      input eeprom;
      input opt;
      input [AW-1:0] addr;
      input [7:0] bound;
      begin
         if (eeprom) begin
            region_of = `PFG_RGN_EE;
         end else if (opt) begin
            region_of = `PFG_RGN_OPT;
         end else if ({{(32-AW){1'b0}}, addr} < ({24'h0, bound} << `PFG_BOUND_SHIFT)) begin
            region_of = `PFG_RGN_S0;
         end else begin
            region_of = `PFG_RGN_S1;
         end
      end
   endfunction

   // mode and region to permission
   function allowed;
      input [1:0] mode;
      input [1:0] rgn;
      input lock;
      input in_application_programming;
      input ram;
      begin
         allowed = 1'b0;
         case (mode)
            `PFG_MODE_TOOL: allowed = 1'b1;
            `PFG_MODE_ICC: allowed = ram;
            `PFG_MODE_APP: allowed = in_application_programming &&
               (rgn == `PFG_RGN_S1 || rgn == `PFG_RGN_EE);
            default: allowed = 1'b0;
         endcase
         // lock does not cover eeprom data
         if (lock && rgn != `PFG_RGN_EE) begin
            allowed = 1'b0;
         end
      end
   endfunction

   // ==========================================
   // request gate
   wire [1:0] cmd_rgn = region_of(cmd_eeprom_i, flash_control_status_q[`PFG_FLASH_CONTROL_STATUS_OPT], cmd_addr_i, bound_q);
   // iap needs the driver running out of sector 0
   wire iap_live = iap_en_q && exec_in_sector0_i;
   wire grp_room = cmd_erase_i || (grp_cnt_q < GROUP_MAX[5:0]);
   wire cmd_ok = opt_valid_q && unlocked_q && flash_control_status_q[`PFG_FLASH_CONTROL_STATUS_LAT] && grp_room &&
      allowed(mode_q, cmd_rgn, wlock_q, iap_live, exec_in_ram_i);
   wire buf_in_ready;
   wire take = cmd_valid_i && buf_in_ready;
   wire [BW-1:0] buf_out;

   // refused words are still consumed so the core never hangs on them
   assign cmd_ready_o = buf_in_ready;

   pfg_buf2 #(
      .W(BW)
   ) u_buf (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(ce_i),
      .in_valid_i(take && cmd_ok),
      .in_ready_o(buf_in_ready),
      .in_data_i({cmd_erase_i, cmd_rgn, cmd_addr_i, cmd_data_i}),
      .out_valid_o(fl_valid_o),
      .out_ready_i(fl_ready_i),
      .out_data_o(buf_out)
   );

   // erase carries its region so the array clears that sector alone
   assign fl_erase_o = buf_out[BW-1];
   assign fl_region_o = buf_out[BW-2:BW-3];
   assign fl_addr_o = buf_out[AW+7:8];
   assign fl_data_o = buf_out[7:0];

   // ==========================================
   // entry detection while reset pin held low
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         entry_st_q <= ST_RUN;
         edge_cnt_q <= 4'h0;
         link_clk_prev_q <= 1'b1;
         mode_q <= `PFG_MODE_APP;
         boot_vector_sys_o <= 1'b0;
      end else if (ce_i) begin
         link_clk_prev_q <= link_clk_s;
         case (entry_st_q)
            ST_RUN: begin
               if (!rst_pin_n_s) begin
                  entry_st_q <= ST_HELD;
                  edge_cnt_q <= 4'h0;
               end
            end
            ST_HELD: begin
               if (rst_pin_n_s) begin
                  entry_st_q <= ST_RUN;
                  mode_q <= tool_s ? `PFG_MODE_TOOL : `PFG_MODE_APP;
                  boot_vector_sys_o <= 1'b0;
               end else if (link_dat_s) begin
                  // data must stay low through the clock burst
                  edge_cnt_q <= 4'h0;
               end else if (link_rise) begin
                  if (edge_cnt_q == `PFG_ENTRY_EDGES - 4'h1) begin
                     entry_st_q <= ST_ARMED;
                  end
                  edge_cnt_q <= edge_cnt_q + 4'h1;
               end
            end
            ST_ARMED: begin
               if (rst_pin_n_s) begin
                  entry_st_q <= ST_RUN;
                  mode_q <= `PFG_MODE_ICC;
                  boot_vector_sys_o <= 1'b1;
               end
            end
            default: entry_st_q <= ST_RUN;
         endcase
      end
   end

   // ==========================================
   // option byte capture and permanent lock
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         opt_valid_q <= 1'b0;
         bound_q <= 8'h0;
         wlock_q <= 1'b0;
      end else if (ce_i) begin
         // re-read the store each time the reset pin is released
         if (!opt_valid_q || (entry_st_q != ST_RUN && rst_pin_n_s)) begin
            opt_valid_q <= 1'b1;
            bound_q <= {1'b0, opt_byte_i[`PFG_OPT_LOCK_BIT-1:0]};
            wlock_q <= wlock_q | opt_byte_i[`PFG_OPT_LOCK_BIT];
         end
         // programming the lock into the option row takes effect at once
         if (take && cmd_ok && cmd_rgn == `PFG_RGN_OPT && !cmd_erase_i &&
             cmd_data_i[`PFG_OPT_LOCK_BIT]) begin
            wlock_q <= 1'b1;
         end
      end
   end

   // ==========================================
   // register writes, unlock keys, group count
   wire wr_flash_control_status = reg_wr_i && reg_addr_i == `PFG_REG_FLASH_CONTROL_STATUS;
   wire grp_end = take && cmd_ok && (cmd_last_i || cmd_erase_i);

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flash_control_status_q <= `PFG_FLASH_CONTROL_STATUS_RST;
         key1_seen_q <= 1'b0;
         unlocked_q <= 1'b0;
         iap_en_q <= 1'b0;
         grp_cnt_q <= 6'h0;
         refused_q <= 8'h0;
      end else if (ce_i) begin
         if (wr_flash_control_status) begin
            if (unlocked_q) begin
               flash_control_status_q <= reg_wdata_i[2:0];
            end else if (key1_seen_q && reg_wdata_i == `PFG_KEY2) begin
               unlocked_q <= 1'b1;
               key1_seen_q <= 1'b0;
            end else begin
               key1_seen_q <= (reg_wdata_i == `PFG_KEY1);
            end
         end
         if (reg_wr_i && reg_addr_i == `PFG_REG_CTRL) begin
            iap_en_q <= reg_wdata_i[`PFG_CTRL_IAP];
         end
         if (grp_end) begin
            // group done: close latch, relock until keys come again
            flash_control_status_q[`PFG_FLASH_CONTROL_STATUS_LAT] <= 1'b0;
            flash_control_status_q[`PFG_FLASH_CONTROL_STATUS_PGM] <= 1'b0;
            unlocked_q <= 1'b0;
            grp_cnt_q <= 6'h0;
         end else if (take && cmd_ok) begin
            grp_cnt_q <= grp_cnt_q + 6'h1;
         end
         if (take && !cmd_ok && refused_q != 8'hff) begin
            refused_q <= refused_q + 8'h1;
         end else if (reg_wr_i && reg_addr_i == `PFG_REG_REFUSED) begin
            refused_q <= 8'h0;
         end
      end
   end

   // ==========================================
   // register reads, one cycle later
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h0;
      end else if (ce_i) begin
         reg_rdata_o <= 8'h0;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `PFG_REG_FLASH_CONTROL_STATUS: reg_rdata_o <= {5'h0, flash_control_status_q};
               `PFG_REG_CTRL: reg_rdata_o <= {7'h0, iap_en_q};
               `PFG_REG_STAT: reg_rdata_o <= {2'h0, boot_vector_sys_o, wlock_q,
                  unlocked_q, iap_live, mode_q};
               `PFG_REG_REFUSED: reg_rdata_o <= refused_q;
               default: reg_rdata_o <= 8'h0;
            endcase
         end
      end
   end
endmodule

// *** testbench/pfg_tool.sv ***
// programming tool model: drives the device reset pin and the two link pins
// assumes the link pins idle high through pull-ups between frames
module pfg_tool (
   // pins toward the device
   output logic rst_pin_n_o,
   output logic sclk_o,
   output logic sdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rst_pin_n_o = 1'b1;
      sclk_o = 1'b1;
      sdata_o = 1'b1;
   end
   // ==========
   // entry frame: n link clock rises with data low while reset is held
   task automatic enter(input int n);
      rst_pin_n_o = 1'b0;
      #400 sdata_o = 1'b0;
      repeat (n) begin
         #200 sclk_o = 1'b0;
         #200 sclk_o = 1'b1;
      end
      #400 rst_pin_n_o = 1'b1;
      // released data line falls back to its pull-up
      sdata_o = 1'b1;
   endtask
endmodule

// *** testbench/pfg_top_properties.sv ***
// port checker for the flash mode gating block
// assumes one clock domain; bound into every pfg_top instance
module pfg_checker #(
   parameter AW = 13
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // pins and option byte
   input wire logic rst_pin_n_i,
   input wire logic tool_socket_i,
   input wire logic [7:0] opt_byte_i,
   input wire logic boot_vector_sys_o,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // requests
   input wire logic cmd_valid_i,
   input wire logic cmd_ready_o,
   input wire logic cmd_erase_i,
   input wire logic cmd_eeprom_i,
   input wire logic [AW-1:0] cmd_addr_i,
   input wire logic [7:0] cmd_data_i,
   // array side
   input wire logic fl_valid_o,
   input wire logic fl_ready_i,
   input wire logic fl_erase_o,
   input wire logic [1:0] fl_region_o,
   input wire logic [AW-1:0] fl_addr_o,
   input wire logic [7:0] fl_data_o
);
   logic tool_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // socket level seen while the pin is held: approximates the mode pick
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         tool_q <= 1'b0;
      else if (!rst_pin_n_i)
         tool_q <= tool_socket_i;
   end
   // ==========
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_zero_a: assert property (reg_rd_i && reg_addr_i > 8'h03 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   hold_out_a: assert property (fl_valid_o && !fl_ready_i && ce_i |=> !ce_i
      || (fl_valid_o && $stable({fl_erase_o, fl_region_o, fl_addr_o, fl_data_o})))
      else $error("array word changed before taken");
   ce_freeze_a: assert property (!ce_i |-> !cmd_ready_o && !fl_valid_o)
      else $error("handshake live while disabled");
   word_origin_a: assert property ($rose(fl_valid_o) && $past(ce_i)
      |-> $past(cmd_valid_i && cmd_ready_o)) else $error("array word without request");
   word_pass_a: assert property ($rose(fl_valid_o) && $past(ce_i) |->
      fl_addr_o == $past(cmd_addr_i) && fl_data_o == $past(cmd_data_i)
      && fl_erase_o == $past(cmd_erase_i) && (fl_region_o == 2'h3) == $past(cmd_eeprom_i))
      else $error("array word differs from request");
   sector_bound_a: assert property (fl_valid_o && !fl_region_o[1] |->
      fl_region_o[0] == (32'(fl_addr_o) >= 32'(opt_byte_i[6:0]) * 512))
      else $error("sector split not at option byte bound");
   s0_guard_a: assert property (fl_valid_o && fl_region_o == 2'h0
      |-> boot_vector_sys_o || tool_q) else $error("sector 0 written in application mode");
   lock_ee_a: assert property (fl_valid_o && opt_byte_i[7] |-> fl_region_o == 2'h3)
      else $error("locked program memory written");
   vector_pin_a: assert property ($rose(boot_vector_sys_o) |-> rst_pin_n_i)
      else $error("system vector raised while reset pin held");
   cover property (fl_valid_o && !fl_ready_i ##1 fl_valid_o);
   cover property ($rose(boot_vector_sys_o));
   cover property (fl_valid_o && fl_erase_o);
endmodule

bind pfg_top pfg_checker #(.AW(AW)) chk (.clk_i, .sys_rst_i, .ce_i, .rst_pin_n_i,
   .tool_socket_i, .opt_byte_i, .boot_vector_sys_o, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
   .cmd_valid_i, .cmd_ready_o, .cmd_erase_i, .cmd_eeprom_i, .cmd_addr_i, .cmd_data_i,
   .fl_valid_o, .fl_ready_i, .fl_erase_o, .fl_region_o, .fl_addr_o, .fl_data_o);

// *** testbench/pfg_top_test.sv ***
// self-checking bench for the flash mode gating block
// assumes the tool model owns the reset pin and both link pins
`include "pfg_map.vh"
module pfg_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, sys_rst_i, ce_i, tool_socket_i, exec_in_sector0_i, exec_in_ram_i, fl_ready_i;
   logic reg_wr_i, reg_rd_i, cmd_valid_i, cmd_erase_i, cmd_eeprom_i, cmd_last_i;
   logic [7:0] opt_byte_i, reg_addr_i, reg_wdata_i, cmd_data_i, reg_rdata_o, fl_data_o;
   logic [12:0] cmd_addr_i, fl_addr_o;
   logic [1:0] fl_region_o;
   logic boot_vector_sys_o, cmd_ready_o, fl_valid_o, fl_erase_o;
   wire rst_pin_n_i, link_serial_clock_pin_i, link_serial_data_pin_i;
   int n_mismatch, n_tests, nref;
   pfg_top DUT (.clk_i, .sys_rst_i, .ce_i, .rst_pin_n_i, .link_serial_clock_pin_i,
      .link_serial_data_pin_i, .tool_socket_i, .opt_byte_i, .exec_in_sector0_i,
      .exec_in_ram_i, .boot_vector_sys_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .cmd_valid_i, .cmd_ready_o, .cmd_erase_i, .cmd_eeprom_i, .cmd_last_i,
      .cmd_addr_i, .cmd_data_i, .fl_valid_o, .fl_ready_i, .fl_erase_o, .fl_region_o,
      .fl_addr_o, .fl_data_o);
   pfg_tool tool (.rst_pin_n_o(rst_pin_n_i), .sclk_o(link_serial_clock_pin_i),
      .sdata_o(link_serial_data_pin_i));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // ==========
   task automatic stop_test();
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [23:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reset();
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      nref = 0;
      // first edge captures the option byte
      repeat (2) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, exp);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      check($sformatf("reg %0h", a), reg_rdata_o, exp);
   endtask
   task automatic arm(input logic [7:0] f);
      wr(`PFG_REG_FLASH_CONTROL_STATUS, `PFG_KEY1);
      wr(`PFG_REG_FLASH_CONTROL_STATUS, `PFG_KEY2);
      wr(`PFG_REG_FLASH_CONTROL_STATUS, f);
   endtask
   // one request; ok says whether it must reach the array
   task automatic req(input logic e, ee, l, input logic [12:0] a, input logic ok,
      input logic [1:0] rg);
      logic got;
      got = 1'b0;
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      {cmd_erase_i, cmd_eeprom_i, cmd_last_i, cmd_addr_i} <= {e, ee, l, a};
      cmd_data_i <= a[7:0] ^ 8'h5a;
      for (int i = 0; i < 20 && !got; i++) begin
         @(negedge clk_i);
         got = cmd_ready_o === 1'b1;
         @(posedge clk_i);
      end
      cmd_valid_i <= 1'b0;
      if (!got) begin
         n_mismatch++;
         stop_test();
      end
      if (!ok)
         nref++;
      @(negedge clk_i);
      check("fl valid", fl_valid_o, ok);
      if (ok)
         check("fl word", {fl_erase_o, fl_region_o, fl_addr_o, fl_data_o},
            {e, rg, a, a[7:0] ^ 8'h5a});
   endtask
   // ==========
   initial begin
      {sys_rst_i, ce_i, fl_ready_i, tool_socket_i, exec_in_sector0_i} = 5'h1c;
      {exec_in_ram_i, reg_wr_i, reg_rd_i, cmd_valid_i, cmd_erase_i} = 5'h00;
      {cmd_eeprom_i, cmd_last_i, reg_addr_i, reg_wdata_i, cmd_data_i} = 26'h0;
      {opt_byte_i, cmd_addr_i, n_mismatch, n_tests} = {8'h04, 13'h0, 64'h0};
      reset();
      rdc(`PFG_REG_FLASH_CONTROL_STATUS, 8'h00);
      rdc(`PFG_REG_STAT, 8'h00);
      rdc(8'h10, 8'h00);
      req(0, 1, 0, 13'h0020, 0, 0);
      @(posedge clk_i);
      ce_i <= 1'b0;
      @(negedge clk_i);
      check("frozen", {cmd_ready_o, fl_valid_o}, 2'h0);
      @(posedge clk_i);
      ce_i <= 1'b1;
      // application mode gating against a 2 Kbyte sector 0
      arm(8'h02);
      wr(`PFG_REG_CTRL, 8'h01);
      req(0, 1, 0, 13'h0020, 0, 0);
      @(posedge clk_i);
      exec_in_sector0_i <= 1'b1;
      req(0, 0, 0, 13'h07ff, 0, 0);
      req(0, 1, 0, 13'h0020, 1, `PFG_RGN_EE);
      req(0, 0, 1, 13'h0800, 1, `PFG_RGN_S1);
      req(0, 0, 0, 13'h0900, 0, 0);
      rdc(`PFG_REG_REFUSED, nref[7:0]);
      wr(`PFG_REG_REFUSED, 8'h00);
      rdc(`PFG_REG_REFUSED, 8'h00);
      // full group, one byte too many, then sector erases
      arm(8'h02);
      for (int i = 0; i < 32; i++)
         req(0, 0, 0, 13'h1000 + 13'(i), 1, `PFG_RGN_S1);
      req(0, 0, 0, 13'h1020, 0, 0);
      req(1, 0, 0, 13'h0000, 0, 0);
      req(1, 0, 0, 13'h1000, 1, `PFG_RGN_S1);
      req(0, 0, 0, 13'h1000, 0, 0);
      // array stalls: two words fill the buffer
      arm(8'h02);
      @(posedge clk_i);
      fl_ready_i <= 1'b0;
      req(0, 0, 0, 13'h1100, 1, `PFG_RGN_S1);
      req(0, 0, 1, 13'h1100, 1, `PFG_RGN_S1);
      check("full", cmd_ready_o, 1'b0);
      @(posedge clk_i);
      fl_ready_i <= 1'b1;
      repeat (2) @(negedge clk_i);
      check("second", fl_valid_o, 1'b1);
      @(negedge clk_i);
      check("empty", fl_valid_o, 1'b0);
      // entry frame one edge short, then complete; iap off keeps the iap bit clear in status
      wr(`PFG_REG_CTRL, 8'h00);
      tool.enter(4);
      repeat (10) @(posedge clk_i);
      rdc(`PFG_REG_STAT, 8'h00);
      tool.enter(5);
      for (int i = 0; i < 20 && boot_vector_sys_o !== 1'b1; i++)
         @(negedge clk_i);
      check("vector", boot_vector_sys_o, 1'b1);
      if (boot_vector_sys_o !== 1'b1)
         stop_test();
      rdc(`PFG_REG_STAT, 8'h21);
      arm(8'h02);
      req(0, 0, 0, 13'h0100, 0, 0);
      @(posedge clk_i);
      exec_in_ram_i <= 1'b1;
      req(0, 0, 1, 13'h0100, 1, `PFG_RGN_S0);
      // socket mode, then the option row sets the lock
      @(posedge clk_i);
      {tool_socket_i, exec_in_ram_i} <= 2'h2;
      tool.enter(0);
      repeat (10) @(posedge clk_i);
      rdc(`PFG_REG_STAT, 8'h02);
      arm(8'h02);
      req(0, 0, 0, 13'h0000, 1, `PFG_RGN_S0);
      req(0, 1, 0, 13'h0040, 1, `PFG_RGN_EE);
      wr(`PFG_REG_FLASH_CONTROL_STATUS, 8'h06);
      req(0, 0, 1, 13'h00a5, 1, `PFG_RGN_OPT);
      rdc(`PFG_REG_STAT, 8'h12);
      tool.enter(0);
      repeat (10) @(posedge clk_i);
      rdc(`PFG_REG_STAT, 8'h12);
      arm(8'h02);
      req(1, 0, 0, 13'h1000, 0, 0);
      // lock taken from the option byte at reset
      @(posedge clk_i);
      opt_byte_i <= 8'h84;
      reset();
      rdc(`PFG_REG_STAT, 8'h10);
      arm(8'h02);
      wr(`PFG_REG_CTRL, 8'h01);
      req(0, 1, 0, 13'h0030, 1, `PFG_RGN_EE);
      req(0, 0, 0, 13'h1200, 0, 0);
      stop_test();
   end
endmodule
